// file: logic/iscs_top.sv
// interrupt source control, request, in-service and timer status logic
//
// Notes on behaviour
// - line four control bit 4: one means level high, zero means rising edge.
// - mask bit 3 set blocks the source; clear allows it.
// - control mask bit and global source mask bit are one storage.
// - priority bits 2..0, zero highest, seven lowest.
// - line four control resets to 000f; bits 15..5 reserved zero.
// - timers use types 08, 12, 13 and share one control register.
// - dma0/line five type 0a, dma1/line six type 0b.
// - timer and dma control reset 000f; only mask and priority.
// - serial port 0 type 14, serial port 1 type 11.
// - serial control resets 001f; bit 4 reads one always.
// - dma halt bit set by nmi, cleared by return, stops dma.
// - status bits 2..0 show timer requests; request bit 0 is their or.
// - timer and dma request bits set by peripheral, cleared on acknowledge.
// - external line request bits show the live pin level.
// - request register layout as packed by the read mux; bit 1 zero.
// - serial request bit is or of enabled serial causes.
// - in-service bit set when taken, cleared by matching type written.
// - in-service resets 0000, same layout as request register.
// - in-service bit 0 is or of the timer in-service bits.
// - line four uses type 10.
// - source with priority value above threshold is blocked.
// - non-specific end write clears highest priority in-service source.
// - global mask write updates control register mask bits.
`default_nettype none
module iscs_top (
  // clock and reset
  input  wire logic                  CLK_SYS,
  input  wire logic                  RSTN,
  // register port
  input  wire logic [7:0]            ADDR,
  input  wire logic [15:0]           WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output var  logic [15:0]           RDATA,
  // peripheral requests
  input  wire logic [2:0]            TMR_EVENT,
  input  wire logic [1:0]            DMA_EVENT,
  input  wire logic [4:0]            EXT_LINES,
  input  wire iscs_pkg::iscs_serial_t SP0_IRQ,
  input  wire iscs_pkg::iscs_serial_t SP1_IRQ,
  // core events and dma halt
  input  wire logic                  NMI_EVENT,
  input  wire logic                  IRET_EVENT,
  output var  logic                  DMA_HALT,
  // acknowledge handshake with the core
  output var  iscs_pkg::iscs_vec_t   IRQ_VEC,
  input  wire logic                  IRQ_ACK
);
  import iscs_pkg::*;

  // ==========================================================================
  // state
  logic [10:0]     mask_reg,      mask_next;
  logic [2:0]      prio_reg [ISCS_NCTL];
  logic [2:0]      prio_next [ISCS_NCTL];
  logic            ext4_lvl_reg,  ext4_lvl_next;
  logic [2:0]      thresh_reg,    thresh_next;
  logic [2:0]      tmr_pend_reg,  tmr_pend_next;
  logic [1:0]      dma_pend_reg,  dma_pend_next;
  logic            ext4_edge_reg, ext4_edge_next;
  logic            ext4_prev_reg, ext4_prev_next;
  logic            dhalt_reg,     dhalt_next;
  logic [7:0]      insvc_reg,     insvc_next;
  logic [2:0]      win_reg,       win_next;
  iscs_vec_t       vec_reg,       vec_next;
  logic [15:0]     rdata_reg,     rdata_next;

  // ==========================================================================
  // per source pending and eligibility
  logic [ISCS_NSRC-1:0] pend;
  logic [ISCS_NSRC-1:0] elig;
  logic                 sp0_req;
  logic                 sp1_req;
  logic                 ext4_pend;
  logic [15:0]          req_word;
  logic [15:0]          insvc_word;

  assign sp0_req = |(SP0_IRQ.cause & SP0_IRQ.enable);
  assign sp1_req = |(SP1_IRQ.cause & SP1_IRQ.enable);
  assign ext4_pend = ext4_lvl_reg ? EXT_LINES[4] : ext4_edge_reg;

  assign pend = {sp0_req, sp1_req, ext4_pend, dma_pend_reg, tmr_pend_reg};

  genvar gi;
  generate
    for (gi = 0; gi < ISCS_NSRC; gi++) begin : g_elig
      // mask gate, threshold gate; a source already in service waits
      assign elig[gi] = pend[gi] & ~mask_reg[ISCS_CTL_MSKBIT[ISCS_SRC_CTL[gi]]]
                        & (prio_reg[ISCS_SRC_CTL[gi]] <= thresh_reg) & ~insvc_reg[gi];
    end
  endgenerate

  // request register layout, timer or, live pins
  always_comb begin
    req_word = 16'h0000;
    req_word[ISCS_BIT_TMR]  = |tmr_pend_reg;
    req_word[ISCS_BIT_DMA0] = dma_pend_reg[0];
    req_word[ISCS_BIT_DMA1] = dma_pend_reg[1];
    req_word[ISCS_BIT_EXT4:ISCS_BIT_EXT0] = EXT_LINES;
    req_word[ISCS_BIT_SP1]  = sp1_req;
    req_word[ISCS_BIT_SP0]  = sp0_req;
  end

  always_comb begin
    insvc_word = ISCS_RST_INSVC;
    insvc_word[ISCS_BIT_TMR]  = |insvc_reg[2:0];
    insvc_word[ISCS_BIT_DMA0] = insvc_reg[3];
    insvc_word[ISCS_BIT_DMA1] = insvc_reg[4];
    insvc_word[ISCS_BIT_EXT4] = insvc_reg[5];
    insvc_word[ISCS_BIT_SP1]  = insvc_reg[6];
    insvc_word[ISCS_BIT_SP0]  = insvc_reg[7];
  end

  // ==========================================================================
  // control register write select
  // decoded once, so the per register write loop stays a plain index test
  logic [ISCS_NCTL-1:0] ctl_wsel;

  always_comb begin
    ctl_wsel = '0;
    if (WR) begin
      unique case (ADDR)
        ISCS_OFF_TCTL:    ctl_wsel[0] = 1'b1;
        ISCS_OFF_DMA0CTL: ctl_wsel[1] = 1'b1;
        ISCS_OFF_DMA1CTL: ctl_wsel[2] = 1'b1;
        ISCS_OFF_EXT4CTL: ctl_wsel[3] = 1'b1;
        ISCS_OFF_SP1CTL:  ctl_wsel[4] = 1'b1;
        ISCS_OFF_SP0CTL:  ctl_wsel[5] = 1'b1;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    logic       eos_found;
    logic [2:0] eos_prio;
    logic [2:0] eos_idx;
    eos_found = 1'b0;
    eos_prio  = 3'h7;
    eos_idx   = 3'h0;

    mask_next      = mask_reg;
    ext4_lvl_next  = ext4_lvl_reg;
    thresh_next    = thresh_reg;
    tmr_pend_next  = tmr_pend_reg;
    dma_pend_next  = dma_pend_reg;
    ext4_edge_next = ext4_edge_reg;
    ext4_prev_next = EXT_LINES[4];
    dhalt_next     = dhalt_reg;
    insvc_next     = insvc_reg;
    for (int c = 0; c < ISCS_NCTL; c++) begin
      prio_next[c] = prio_reg[c];
    end

    // ---- software writes (clears first so hardware sets win below)
    if (WR) begin
      unique case (ADDR)
        ISCS_OFF_TCTL, ISCS_OFF_DMA0CTL, ISCS_OFF_DMA1CTL, ISCS_OFF_EXT4CTL,
        ISCS_OFF_SP1CTL, ISCS_OFF_SP0CTL: begin
          for (int c = 0; c < ISCS_NCTL; c++) begin
            if (ctl_wsel[c]) begin
              // control mask bit lands in the shared mask storage
              mask_next[ISCS_CTL_MSKBIT[c]] = WDATA[ISCS_BIT_MSK];
              prio_next[c] = WDATA[2:0];
            end
          end
          if (ADDR == ISCS_OFF_EXT4CTL) begin
            ext4_lvl_next = WDATA[ISCS_BIT_LVL];
          end
        end
        ISCS_OFF_GMASK: begin
          // one storage, so control registers see it at once
          mask_next    = WDATA[10:0];
          mask_next[1] = 1'b0;
        end
        ISCS_OFF_THRESH: begin
          thresh_next = WDATA[2:0];
        end
        ISCS_OFF_TSTAT: begin
          // software may hold off dma through this bit
          dhalt_next    = WDATA[ISCS_BIT_DHALT];
          tmr_pend_next = WDATA[2:0];
        end
        ISCS_OFF_INSVC: begin
          insvc_next[2:0] = {3{WDATA[ISCS_BIT_TMR]}};
          insvc_next[3]   = WDATA[ISCS_BIT_DMA0];
          insvc_next[4]   = WDATA[ISCS_BIT_DMA1];
          insvc_next[5]   = WDATA[ISCS_BIT_EXT4];
          insvc_next[6]   = WDATA[ISCS_BIT_SP1];
          insvc_next[7]   = WDATA[ISCS_BIT_SP0];
        end
        ISCS_OFF_EOS: begin
          if (WDATA[ISCS_BIT_NSPEC]) begin
            // clear in-service source with best priority
            for (int s = 0; s < ISCS_NSRC; s++) begin
              if (insvc_reg[s] && (!eos_found || prio_reg[ISCS_SRC_CTL[s]] < eos_prio)) begin
                eos_found = 1'b1;
                eos_prio  = prio_reg[ISCS_SRC_CTL[s]];
                eos_idx   = 3'(s);
              end
            end
            if (eos_found) begin
              insvc_next[eos_idx] = 1'b0;
            end
          end else begin
            for (int s = 0; s < ISCS_NSRC; s++) begin
              if (WDATA[4:0] == ISCS_SRC_TYPE[s][4:0]) begin
                insvc_next[s] = 1'b0;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ---- acknowledge of the presented source
    if (IRQ_ACK && vec_reg.valid) begin
      if (win_reg < 3'h3) begin
        tmr_pend_next[win_reg[1:0]] = 1'b0;
      end else if (win_reg < 3'h5) begin
        dma_pend_next[1'(win_reg - 3'h3)] = 1'b0;
      end else if (win_reg == 3'h5) begin
        ext4_edge_next = 1'b0;
      end
      insvc_next[win_reg] = 1'b1;
    end

    // ---- hardware sets, placed last so they win over clears
    // peripheral sets pending
    tmr_pend_next = tmr_pend_next | TMR_EVENT;
    dma_pend_next = dma_pend_next | DMA_EVENT;
    if (EXT_LINES[4] && !ext4_prev_reg) begin
      ext4_edge_next = 1'b1;
    end
    // nmi sets halt, return clears it; the set wins
    if (IRET_EVENT) begin
      dhalt_next = 1'b0;
    end
    if (NMI_EVENT) begin
      dhalt_next = 1'b1;
    end

  end

  // ==========================================================================
  // presentation to the core
  always_comb begin
    logic       found;
    logic [2:0] best_prio;
    logic [2:0] best_idx;
    found     = 1'b0;
    best_prio = 3'h7;
    best_idx  = 3'h0;
    // pick lowest priority value, lower index on a tie
    for (int s = 0; s < ISCS_NSRC; s++) begin
      if (elig[s] && (!found || prio_reg[ISCS_SRC_CTL[s]] < best_prio)) begin
        found     = 1'b1;
        best_prio = prio_reg[ISCS_SRC_CTL[s]];
        best_idx  = 3'(s);
      end
    end
    win_next = best_idx;
    vec_next.valid = found;
    vec_next.itype = ISCS_SRC_TYPE[best_idx];
    // a vector just acknowledged is withdrawn for one cycle
    if (IRQ_ACK && vec_reg.valid) begin
      vec_next.valid = 1'b0;
    end
  end

  // ==========================================================================
  // read data, one cycle after the strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (RD) begin
      unique case (ADDR)
        // timer and dma control: mask and priority only
        ISCS_OFF_TCTL:    rdata_next = {12'h000, mask_reg[ISCS_CTL_MSKBIT[0]], prio_reg[0]};
        ISCS_OFF_DMA0CTL: rdata_next = {12'h000, mask_reg[ISCS_CTL_MSKBIT[1]], prio_reg[1]};
        ISCS_OFF_DMA1CTL: rdata_next = {12'h000, mask_reg[ISCS_CTL_MSKBIT[2]], prio_reg[2]};
        ISCS_OFF_EXT4CTL: rdata_next = {11'h000, ext4_lvl_reg, mask_reg[ISCS_CTL_MSKBIT[3]], prio_reg[3]};
        ISCS_OFF_SP1CTL:  rdata_next = {11'h000, 1'b1, mask_reg[ISCS_CTL_MSKBIT[4]], prio_reg[4]};
        ISCS_OFF_SP0CTL:  rdata_next = {11'h000, 1'b1, mask_reg[ISCS_CTL_MSKBIT[5]], prio_reg[5]};
        ISCS_OFF_GMASK:   rdata_next = {5'h00, mask_reg};
        ISCS_OFF_THRESH:  rdata_next = {13'h0000, thresh_reg};
        ISCS_OFF_TSTAT:   rdata_next = {dhalt_reg, 12'h000, tmr_pend_reg};
        ISCS_OFF_REQ:     rdata_next = req_word;
        ISCS_OFF_INSVC:   rdata_next = insvc_word;
        default:          rdata_next = 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mask_reg      <= ISCS_RST_GMASK[10:0];
      // control resets: mask set, priority seven, edge mode
      for (int c = 0; c < ISCS_NCTL; c++) begin
        prio_reg[c] <= ISCS_RST_CTL[2:0];
      end
      ext4_lvl_reg  <= ISCS_RST_CTL[ISCS_BIT_LVL];
      thresh_reg    <= ISCS_RST_THRESH;
      tmr_pend_reg  <= 3'h0;
      dma_pend_reg  <= 2'h0;
      ext4_edge_reg <= 1'b0;
      ext4_prev_reg <= 1'b0;
      dhalt_reg     <= 1'b0;
      insvc_reg     <= ISCS_RST_INSVC[7:0];
    end else begin
      mask_reg      <= mask_next;
      for (int c = 0; c < ISCS_NCTL; c++) begin
        prio_reg[c] <= prio_next[c];
      end
      ext4_lvl_reg  <= ext4_lvl_next;
      thresh_reg    <= thresh_next;
      tmr_pend_reg  <= tmr_pend_next;
      dma_pend_reg  <= dma_pend_next;
      ext4_edge_reg <= ext4_edge_next;
      ext4_prev_reg <= ext4_prev_next;
      dhalt_reg     <= dhalt_next;
      insvc_reg     <= insvc_next;
    end
  end

  // presentation registers
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      win_reg <= 3'h0;
      vec_reg <= '0;
    end else begin
      win_reg <= win_next;
      vec_reg <= vec_next;
    end
  end

  // read data register, zero outside the cycle after a read
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================================
  // outputs
  assign RDATA    = rdata_reg;
  // halt drives the dma engine stop
  assign DMA_HALT = dhalt_reg;
  assign IRQ_VEC  = vec_reg;

endmodule : iscs_top
`default_nettype wire

// file: logic/iscs_pkg.sv
// constants and carrier types for the interrupt source control and status block
`default_nettype none
package iscs_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ISCS_OFF_EOS     = 8'h22;
  localparam logic [7:0] ISCS_OFF_GMASK   = 8'h28;
  localparam logic [7:0] ISCS_OFF_THRESH  = 8'h2a;
  localparam logic [7:0] ISCS_OFF_INSVC   = 8'h2c;
  localparam logic [7:0] ISCS_OFF_REQ     = 8'h2e;
  localparam logic [7:0] ISCS_OFF_TSTAT   = 8'h30;
  localparam logic [7:0] ISCS_OFF_TCTL    = 8'h32;
  localparam logic [7:0] ISCS_OFF_DMA0CTL = 8'h34;
  localparam logic [7:0] ISCS_OFF_DMA1CTL = 8'h36;
  localparam logic [7:0] ISCS_OFF_EXT4CTL = 8'h40;
  localparam logic [7:0] ISCS_OFF_SP1CTL  = 8'h42;
  localparam logic [7:0] ISCS_OFF_SP0CTL  = 8'h44;

  // ==========================================================================
  // field positions
  localparam int ISCS_BIT_LVL    = 4;
  localparam int ISCS_BIT_MSK    = 3;
  localparam int ISCS_BIT_DHALT  = 15;
  localparam int ISCS_BIT_NSPEC  = 15;
  localparam int ISCS_BIT_TMR    = 0;
  localparam int ISCS_BIT_DMA0   = 2;
  localparam int ISCS_BIT_DMA1   = 3;
  localparam int ISCS_BIT_EXT0   = 4;
  localparam int ISCS_BIT_EXT4   = 8;
  localparam int ISCS_BIT_SP1    = 9;
  localparam int ISCS_BIT_SP0    = 10;

  // ==========================================================================
  // reset values
  localparam logic [15:0] ISCS_RST_CTL     = 16'h000f;
  localparam logic [15:0] ISCS_RST_SPCTL   = 16'h001f;
  localparam logic [15:0] ISCS_RST_GMASK   = 16'h07fd;
  localparam logic [2:0]  ISCS_RST_THRESH  = 3'h7;
  localparam logic [15:0] ISCS_RST_INSVC   = 16'h0000;

  // ==========================================================================
  // sources: index, owning control register, interrupt type
  localparam int ISCS_NSRC = 8;
  localparam int ISCS_NCTL = 6;
  // control register order: timer, dma0, dma1, ext4, sp1, sp0
  localparam int ISCS_CTL_MSKBIT [ISCS_NCTL] = '{0, 2, 3, 8, 9, 10};
  // source order: tmr0, tmr1, tmr2, dma0, dma1, ext4, sp1, sp0
  localparam int ISCS_SRC_CTL [ISCS_NSRC] = '{0, 0, 0, 1, 2, 3, 4, 5};
  localparam logic [7:0] ISCS_SRC_TYPE [ISCS_NSRC] =
    '{8'h08, 8'h12, 8'h13, 8'h0a, 8'h0b, 8'h10, 8'h11, 8'h14};

  // ==========================================================================
  // carriers to the processor core and from the serial ports
  typedef struct packed {
    logic       valid;
    logic [7:0] itype;
  } iscs_vec_t;

  typedef struct packed {
    logic [6:0] cause;
    logic [6:0] enable;
  } iscs_serial_t;

endpackage : iscs_pkg
`default_nettype wire

// file: tb/iscs_top_properties.sv
// port-level assertions for the interrupt source control block
`default_nettype none
module iscs_props (
  // clock and reset
  input wire logic                CLK_SYS,
  input wire logic                RSTN,
  // register port
  input wire logic [7:0]          ADDR,
  input wire logic                WR,
  input wire logic                RD,
  input wire logic [15:0]         RDATA,
  // core side
  input wire logic                NMI_EVENT,
  input wire logic                IRET_EVENT,
  input wire logic                DMA_HALT,
  input wire iscs_pkg::iscs_vec_t IRQ_VEC,
  input wire logic                IRQ_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  import iscs_pkg::*;
  // ==========================================================================
  // properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  a_halt_nmi_set: assert property (NMI_EVENT |=> DMA_HALT)
    else $error("dma halt not set after nmi");
  a_halt_iret_clear: assert property (IRET_EVENT && !NMI_EVENT && !WR |=> !DMA_HALT)
    else $error("dma halt not cleared after return");
  a_halt_quiet_hold: assert property (!NMI_EVENT && !IRET_EVENT && !(WR && ADDR == 8'h30) |=> $stable(DMA_HALT))
    else $error("dma halt moved without cause");
  a_vec_ack_drop: assert property (IRQ_VEC.valid && IRQ_ACK |=> !IRQ_VEC.valid)
    else $error("vector still valid after acknowledge");
  a_vec_type_known: assert property (IRQ_VEC.valid |-> IRQ_VEC.itype inside {8'h08, 8'h12, 8'h13,
    8'h0a, 8'h0b, 8'h10, 8'h11, 8'h14})
    else $error("presented type not a source type");
  a_ctl_reserved_zero: assert property ($past(RD) && $past(ADDR) inside {8'h32, 8'h34, 8'h36}
    |-> RDATA[15:4] == 12'h000)
    else $error("timer or dma control reserved bits not zero");
  a_serial_bit_four: assert property ($past(RD) && $past(ADDR) inside {8'h42, 8'h44} |-> RDATA[15:4] == 12'h001)
    else $error("serial control bit four not one");
  a_ext_reserved_zero: assert property ($past(RD) && $past(ADDR) == 8'h40 |-> RDATA[15:5] == 11'h000)
    else $error("line four control reserved bits not zero");
  a_req_reserved_zero: assert property ($past(RD) && $past(ADDR) == 8'h2e
    |-> RDATA[15:11] == 5'h00 && !RDATA[1])
    else $error("request register reserved bits not zero");
endmodule : iscs_props
bind iscs_top iscs_props u_props (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
  .NMI_EVENT(NMI_EVENT), .IRET_EVENT(IRET_EVENT), .DMA_HALT(DMA_HALT), .IRQ_VEC(IRQ_VEC), .IRQ_ACK(IRQ_ACK));
`default_nettype wire

// file: tb/iscs_core_model.sv
// processor core model that acknowledges presented interrupts
`default_nettype none
module iscs_core_model (
  // clock and reset
  input wire logic                clk,
  input wire logic                rstn,
  // vector handshake
  input wire iscs_pkg::iscs_vec_t vec,
  output var logic                ack,
  // behaviour selects
  input wire logic                enable,
  input wire logic                slow
);
  timeunit 1ns;
  timeprecision 1ps;
  import iscs_pkg::*;
  logic [2:0] wait_reg;
  logic [2:0] wait_next;
  logic       ack_next;
  // ==========================================================================
  // acknowledge; never on the cycle after its own ack, the vector is stale then
  always_comb begin
    wait_next = wait_reg;
    ack_next  = 1'b0;
    if (vec.valid && enable && !ack) begin
      if (!slow || wait_reg == 3'h4) begin
        ack_next  = 1'b1;
        wait_next = 3'h0;
      end else begin
        wait_next = wait_reg + 3'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack      <= 1'b0;
      wait_reg <= 3'h0;
    end else begin
      ack      <= ack_next;
      wait_reg <= wait_next;
    end
  end
endmodule : iscs_core_model
`default_nettype wire

// file: tb/tb_irq_source_control_status.sv
// self-checking bench for the interrupt source control block
`default_nettype none
module tb_irq_source_control_status;
  timeunit 1ns;
  timeprecision 1ps;
  import iscs_pkg::*;
  typedef struct {logic wr; logic [7:0] wa; logic [15:0] wd; logic [7:0] ra; logic [15:0] exp;} iscs_row_t;
  logic clk_sys, rstn, wr, rd, nmi, iret, halt, ack, core_en, core_slow;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, val;
  logic [2:0] tmr;
  logic [1:0] dma;
  logic [4:0] ext;
  iscs_serial_t sp0, sp1;
  iscs_vec_t vec;
  logic [7:0] got[$];
  int mismatches = 0;
  int checks = 0;
  iscs_row_t rows [19] = '{'{0, 0, 0, 8'h32, 16'h000f}, '{0, 0, 0, 8'h34, 16'h000f}, '{0, 0, 0, 8'h36, 16'h000f},
    '{0, 0, 0, 8'h40, 16'h000f}, '{0, 0, 0, 8'h42, 16'h001f}, '{0, 0, 0, 8'h44, 16'h001f},
    '{0, 0, 0, 8'h2c, 16'h0000}, '{0, 0, 0, 8'h30, 16'h0000}, '{0, 0, 0, 8'h28, 16'h07fd},
    '{0, 0, 0, 8'h2a, 16'h0007}, '{0, 0, 0, 8'h50, 16'h0000}, '{0, 0, 0, 8'h22, 16'h0000},
    '{1, 8'h32, 16'h0002, 8'h32, 16'h0002}, '{1, 8'h32, 16'h0002, 8'h28, 16'h07fc},
    '{1, 8'h28, 16'h07fd, 8'h32, 16'h000a}, '{1, 8'h40, 16'h0017, 8'h40, 16'h0017},
    '{1, 8'h42, 16'h0015, 8'h42, 16'h0015}, '{1, 8'h2e, 16'hffff, 8'h2e, 16'h0000},
    '{1, 8'h50, 16'hffff, 8'h50, 16'h0000}};
  logic [23:0] setup [6] = '{24'h320003, 24'h340001, 24'h360000, 24'h400002, 24'h420014, 24'h440015};
  logic [7:0] order [8] = '{8'h0b, 8'h0a, 8'h10, 8'h08, 8'h12, 8'h13, 8'h11, 8'h14};

  iscs_top DUT (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TMR_EVENT(tmr), .DMA_EVENT(dma), .EXT_LINES(ext), .SP0_IRQ(sp0), .SP1_IRQ(sp1), .NMI_EVENT(nmi),
    .IRET_EVENT(iret), .DMA_HALT(halt), .IRQ_VEC(vec), .IRQ_ACK(ack));
  iscs_core_model u_core (.clk(clk_sys), .rstn(rstn), .vec(vec), .ack(ack), .enable(core_en), .slow(core_slow));

  // ==========================================================================
  // shared tasks
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wrt(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wrt
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata, exp);
  endtask : rdc
  task automatic pulse(input logic [2:0] t, input logic [1:0] d, input logic n, input logic i);
    @(posedge clk_sys);
    {tmr, dma, nmi, iret} <= {t, d, n, i};
    @(posedge clk_sys);
    {tmr, dma, nmi, iret} <= 7'h00;
  endtask : pulse
  task automatic vec_is(input logic v, input logic [7:0] t);
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < 40 && vec.valid !== v; k++) @(posedge clk_sys);
    #1 chk("vector", {7'h00, vec.valid, v ? vec.itype : 8'h00}, {7'h00, v, t});
  endtask : vec_is
  task automatic run_rows(input int hi);
    foreach (rows[r]) if (r <= hi) begin
      if (rows[r].wr) wrt(rows[r].wa, rows[r].wd);
      rdc(rows[r].ra, rows[r].exp);
    end
  endtask : run_rows
  task automatic test_done;
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  always @(posedge clk_sys) if (ack && vec.valid) got.push_back(vec.itype);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end

  // ==========================================================================
  // main sequence
  initial begin
    {rstn, wr, rd, nmi, iret, core_en, core_slow, tmr, dma, ext, addr, wdata} = '0;
    {sp0, sp1} = '0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    run_rows(18);
    foreach (setup[s]) wrt(setup[s][23:16], setup[s][15:0]);
    // held high through and after the acknowledges
    ext <= 5'h1f;
    sp0 <= {7'h01, 7'h01};
    sp1 <= {7'h40, 7'h40};
    pulse(3'h7, 2'h3, 1'b0, 1'b0);
    rdc(8'h2e, 16'h07fd);
    rdc(8'h30, 16'h0007);
    {core_en, core_slow} <= 2'b11;
    for (int k = 0; k < 400 && got.size() < 8; k++) @(posedge clk_sys);
    foreach (order[o]) chk("taken type", {8'h00, got.size() > o ? got[o] : 8'hff}, {8'h00, order[o]});
    core_en <= 1'b0;
    // causes left up with their enables off must not request
    sp0 <= {7'h7e, 7'h01};
    sp1 <= {7'h3f, 7'h40};
    rdc(8'h2e, 16'h01f0);
    rdc(8'h30, 16'h0000);
    rdc(8'h2c, 16'h070d);
    wrt(8'h22, 16'h0008);
    wrt(8'h22, 16'h0012);
    rdc(8'h2c, 16'h070d);
    wrt(8'h22, 16'h0013);
    rdc(8'h2c, 16'h070c);
    wrt(8'h22, 16'h8000);
    rdc(8'h2c, 16'h0704);
    wrt(8'h2c, 16'h0000);
    // edge already consumed, level mode fires on the held pin
    vec_is(1'b0, 8'h00);
    wrt(8'h40, 16'h0012);
    vec_is(1'b1, 8'h10);
    ext[4] <= 1'b0;
    vec_is(1'b0, 8'h00);
    wrt(8'h2a, 16'h0002);
    pulse(3'h1, 2'h0, 1'b0, 1'b0);
    vec_is(1'b0, 8'h00);
    wrt(8'h2a, 16'h0003);
    vec_is(1'b1, 8'h08);
    wrt(8'h28, 16'h07fd);
    vec_is(1'b0, 8'h00);
    rdc(8'h32, 16'h000b);
    pulse(3'h0, 2'h0, 1'b1, 1'b0);
    rdc(8'h30, 16'h8001);
    pulse(3'h0, 2'h0, 1'b0, 1'b1);
    rdc(8'h30, 16'h0001);
    // timers masked here, so software may touch the halt bit
    wrt(8'h30, 16'h8000);
    rdc(8'h30, 16'h8000);
    chk("dma halt", {15'h0000, halt}, 16'h0001);
    // nmi and return together: the set wins
    pulse(3'h0, 2'h0, 1'b1, 1'b1);
    rdc(8'h30, 16'h8000);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    run_rows(11);
    test_done();
  end
endmodule : tb_irq_source_control_status
`default_nettype wire
